// ===== shared/rwg_map.vh
// register offsets, field positions, reset values and sizes of the random word generator
`ifndef RWG_MAP_VH
`define RWG_MAP_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define RWG_ADDR_W 8
`define RWG_OFS_ENABLE 8'h60
`define RWG_OFS_CONFIG 8'h64
`define RWG_OFS_DATA 8'h68
`define RWG_OFS_STATUS 8'h6c

// ----------------------------------------
// field positions
// ----------------------------------------
`define RWG_RUN_BIT 0
`define RWG_OUT_DIV_BIT 7
`define RWG_FIRST_DIV_LO 8
`define RWG_FIRST_DIV_HI 11
`define RWG_UNDERFLOW_BIT 12
`define RWG_READY_BIT 14

// ----------------------------------------
// reset values
// ----------------------------------------
`define RWG_ENABLE_RST 1'b0
`define RWG_OUT_DIV_RST 1'b0
`define RWG_FIRST_DIV_RST 4'h0
`define RWG_LFSR_SEED 32'h0000_0001

// ----------------------------------------
// divider exponents (divisor = 2 ** exponent)
// ----------------------------------------
`define RWG_FIRST_EXP_MAX 5'h0f
`define RWG_FIRST_EXP_BASE 5'h10
`define RWG_OUT_EXP_1024 5'h0a
`define RWG_OUT_EXP_512 5'h09
`define RWG_CNT_W 26

// ----------------------------------------
// word pool
// ----------------------------------------
`define RWG_WORD_W 32
`define RWG_POOL_DEPTH 4
`define RWG_POOL_IDX_W 2
`define RWG_POOL_CNT_W 3
`define RWG_READY_MIN 3'h2

`endif

// ===== hw/rwg_word_pool.v
// first-in first-out pool of random words held in flip-flops
`timescale 1ns/100ps
`include "rwg_map.vh"

module rwg_word_pool (
	input wire mclk,
	input wire clr_n,
	input wire in_valid,
	output wire in_ready,
	input wire [`RWG_WORD_W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [`RWG_WORD_W-1:0] out_data,
	output wire [`RWG_POOL_CNT_W-1:0] fill
);

	reg [`RWG_WORD_W-1:0] slot [0:`RWG_POOL_DEPTH-1];
	reg [`RWG_POOL_IDX_W-1:0] head;
	reg [`RWG_POOL_IDX_W-1:0] tail;
	reg [`RWG_POOL_CNT_W-1:0] count;
	wire push;
	wire pop;

	assign in_ready = (count != `RWG_POOL_DEPTH);
	assign out_valid = (count != {`RWG_POOL_CNT_W{1'b0}});
	assign out_data = slot[head];
	assign fill = count;
	// full pool refuses, unread words are never overwritten
	assign push = in_valid & in_ready;
	assign pop = out_ready & out_valid;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < `RWG_POOL_DEPTH; i = i + 1) begin : g_slot
			always @(posedge mclk) begin
				if (!clr_n) begin
					slot[i] <= {`RWG_WORD_W{1'b0}};
				end else if (push && tail == i) begin
					slot[i] <= in_data;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// pointers and fill level
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!clr_n) begin
			head <= {`RWG_POOL_IDX_W{1'b0}};
			tail <= {`RWG_POOL_IDX_W{1'b0}};
			count <= {`RWG_POOL_CNT_W{1'b0}};
		end else begin
			if (push) begin
				tail <= tail + 1'b1;
			end
			if (pop) begin
				head <= head + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule

// ===== hw/rwg_top.v
// random word generator: rate dividers, entropy mixer, word pool and registers
//
// Contract
// - config bit 7 selects output divider 1024/512
// - decode first divider field bits 11:8
// - one word per first times output divider
// - reset clears both dividers, slowest rate
// - data read returns oldest word, removes it
// - ready bit 14 when two words held
// - empty data read sets underflow bit 12
// - underflow sticky until generator reset
// - underflow read returns unspecified value
// - protected mode admits embedded port only
`timescale 1ns/100ps
`include "rwg_map.vh"

module rwg_top (
	input wire mclk,
	input wire rst_n,
	input wire soft_rst,
	input wire protected_mode,
	input wire entropy_bit,
	input wire reg_req,
	input wire reg_wr,
	input wire reg_from_embedded,
	input wire [`RWG_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	output reg reg_ack,
	output reg reg_refused,
	output reg pool_ready_flag,
	output reg pool_underflow_flag
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg entropy_s1;
	reg entropy_s2;
	reg generator_run_bit;
	reg out_div_sel;
	reg [3:0] first_divider;
	reg [31:0] lfsr;
	reg [`RWG_CNT_W-1:0] rate_cnt;
	reg [31:0] next_rdata;
	reg [4:0] first_exp;
	wire clr_n;
	wire [4:0] total_exp;
	wire [`RWG_CNT_W-1:0] rate_limit;
	wire tick;
	wire feedback;
	wire access_ok;
	wire rd_data;
	wire wr_any;
	wire pool_out_valid;
	wire [`RWG_WORD_W-1:0] pool_out_data;
	wire [`RWG_POOL_CNT_W-1:0] pool_fill;

	// hard and soft reset both restart the generator
	assign clr_n = rst_n & ~soft_rst;

	// ----------------------------------------
	// entropy input synchroniser
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			entropy_s1 <= 1'b0;
			entropy_s2 <= 1'b0;
		end else begin
			entropy_s1 <= entropy_bit;
			entropy_s2 <= entropy_s1;
		end
	end

	// ----------------------------------------
	// register access decode
	// ----------------------------------------
	// host side is shut out in protected mode
	assign access_ok = reg_req & (reg_from_embedded | ~protected_mode);
	assign rd_data = access_ok & ~reg_wr & (reg_addr == `RWG_OFS_DATA);
	assign wr_any = access_ok & reg_wr;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!clr_n) begin
			generator_run_bit <= `RWG_ENABLE_RST;
			out_div_sel <= `RWG_OUT_DIV_RST;
			first_divider <= `RWG_FIRST_DIV_RST;
		end else if (wr_any) begin
			if (reg_addr == `RWG_OFS_ENABLE) begin
				generator_run_bit <= reg_wdata[`RWG_RUN_BIT];
			end
			if (reg_addr == `RWG_OFS_CONFIG) begin
				out_div_sel <= reg_wdata[`RWG_OUT_DIV_BIT];
				first_divider <= reg_wdata[`RWG_FIRST_DIV_HI:`RWG_FIRST_DIV_LO];
			end
		end
	end

	// ----------------------------------------
	// rate dividers
	// ----------------------------------------
	// codes 0 and 1 give 2**15, each higher code halves
	always @* begin
		if (first_divider[3:1] == 3'h0) begin
			first_exp = `RWG_FIRST_EXP_MAX;
		end else begin
			first_exp = `RWG_FIRST_EXP_BASE - {1'b0, first_divider};
		end
	end

	assign total_exp = first_exp + (out_div_sel ? `RWG_OUT_EXP_512 : `RWG_OUT_EXP_1024);
	assign rate_limit = ({{(`RWG_CNT_W-1){1'b0}}, 1'b1} << total_exp) - 1'b1;
	// compare with >= so a raised rate never waits for a wrap
	assign tick = generator_run_bit & (rate_cnt >= rate_limit);

	always @(posedge mclk) begin
		if (!clr_n) begin
			rate_cnt <= {`RWG_CNT_W{1'b0}};
		end else if (!generator_run_bit || tick) begin
			rate_cnt <= {`RWG_CNT_W{1'b0}};
		end else begin
			rate_cnt <= rate_cnt + 1'b1;
		end
	end

	// ----------------------------------------
	// entropy mixer
	// ----------------------------------------
	// lfsr whitens the raw bit; it is folded in every running cycle
	assign feedback = lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0] ^ entropy_s2;

	always @(posedge mclk) begin
		if (!clr_n) begin
			lfsr <= `RWG_LFSR_SEED;
		end else if (generator_run_bit) begin
			lfsr <= {lfsr[30:0], feedback};
		end
	end

	// ----------------------------------------
	// word pool
	// ----------------------------------------
	rwg_word_pool u_pool (
		.mclk(mclk),
		.clr_n(clr_n),
		.in_valid(tick),
		.in_ready(),
		.in_data(lfsr),
		.out_valid(pool_out_valid),
		.out_ready(rd_data),
		.out_data(pool_out_data),
		.fill(pool_fill)
	);

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!clr_n) begin
			pool_ready_flag <= 1'b0;
			pool_underflow_flag <= 1'b0;
		end else begin
			pool_ready_flag <= (pool_fill >= `RWG_READY_MIN);
			if (rd_data && !pool_out_valid) begin
				pool_underflow_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always @* begin
		next_rdata = 32'h0000_0000;
		if (access_ok && !reg_wr) begin
			case (reg_addr)
			`RWG_OFS_ENABLE: begin
				next_rdata[`RWG_RUN_BIT] = generator_run_bit;
			end
			`RWG_OFS_CONFIG: begin
				next_rdata[`RWG_OUT_DIV_BIT] = out_div_sel;
				next_rdata[`RWG_FIRST_DIV_HI:`RWG_FIRST_DIV_LO] = first_divider;
			end
			`RWG_OFS_DATA: begin
				// empty pool answers zero
				if (pool_out_valid) begin
					next_rdata = pool_out_data;
				end
			end
			`RWG_OFS_STATUS: begin
				next_rdata[`RWG_READY_BIT] = pool_ready_flag;
				next_rdata[`RWG_UNDERFLOW_BIT] = pool_underflow_flag;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
			endcase
		end
	end

	// ----------------------------------------
	// bus answer
	// ----------------------------------------
	always @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
			reg_ack <= 1'b0;
			reg_refused <= 1'b0;
		end else begin
			reg_rdata <= next_rdata;
			reg_ack <= reg_req;
			reg_refused <= reg_req & ~access_ok;
		end
	end

endmodule

// ===== test/rwg_top_assertions.sv
// port assertions for the random word generator
`timescale 1ns/100ps
`include "rwg_map.vh"
module rwg_top_assertions (
	input wire mclk,
	input wire rst_n,
	input wire soft_rst,
	input wire protected_mode,
	input wire entropy_bit,
	input wire reg_req,
	input wire reg_wr,
	input wire reg_from_embedded,
	input wire [`RWG_ADDR_W-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	input wire reg_ack,
	input wire reg_refused,
	input wire pool_ready_flag,
	input wire pool_underflow_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_ack_follows_req: assert property (reg_req |=> reg_ack)
		else $error("no ack");
	a_ack_has_cause: assert property (reg_ack |-> $past(reg_req))
		else $error("stray ack");
	a_host_refused: assert property (reg_req && protected_mode && !reg_from_embedded |=> reg_refused)
		else $error("host not refused");
	a_embedded_admitted: assert property (reg_req && reg_from_embedded |=> !reg_refused)
		else $error("embedded refused");
	a_refused_reads_zero: assert property (reg_refused |-> reg_ack && reg_rdata == 32'h0)
		else $error("refused answer");
	a_underflow_sticky: assert property (pool_underflow_flag && !soft_rst |=> pool_underflow_flag)
		else $error("underflow lost");
	a_underflow_cause: assert property ($rose(pool_underflow_flag) |->
		$past(reg_req && !reg_wr && reg_addr == `RWG_OFS_DATA
		&& (reg_from_embedded || !protected_mode)))
		else $error("underflow without read");
	a_soft_clears: assert property (soft_rst |=> !pool_ready_flag && !pool_underflow_flag)
		else $error("soft reset kept flags");
endmodule

// ===== test/rwg_cpu_model.sv
// processor side: issues single register accesses
`timescale 1ns/100ps
module rwg_cpu_model (
	input wire mclk,
	input wire reg_ack,
	input wire reg_refused,
	input wire [31:0] reg_rdata,
	output reg reg_req = 1'b0,
	output reg reg_wr = 1'b0,
	output reg reg_from_embedded = 1'b0,
	output reg [7:0] reg_addr = 8'h00,
	output reg [31:0] reg_wdata = 32'h0
);
	integer hang = 0;
	// one-cycle request, answer taken at the ack edge
	task xfer(input e, input w, input [7:0] a, input [31:0] d, output [31:0] q, output f);
		integer n;
		begin
			@(posedge mclk);
			reg_req <= 1'b1;
			reg_wr <= w;
			reg_from_embedded <= e;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge mclk);
			reg_req <= 1'b0;
			n = 0;
			do begin
				@(posedge mclk);
				n = n + 1;
			end while (reg_ack !== 1'b1 && n < 8);
			q = reg_rdata;
			f = reg_refused;
			if (reg_ack !== 1'b1)
				hang = hang + 1;
		end
	endtask
endmodule

// ===== test/random_word_generator_test.sv
// self-checking bench for the random word generator
`timescale 1ns/100ps
`include "rwg_map.vh"
module random_word_generator_test;
	reg mclk = 1'b0;
	reg rst_n = 1'b0;
	reg soft_rst = 1'b0;
	reg protected_mode = 1'b0;
	reg entropy_bit = 1'b0;
	wire reg_req, reg_wr, reg_from_embedded, reg_ack, reg_refused;
	wire pool_ready_flag, pool_underflow_flag;
	wire [7:0] reg_addr;
	wire [31:0] reg_wdata, reg_rdata;
	integer err_total = 0;
	integer compares = 0;
	integer i, n;
	reg [31:0] q, w0;
	reg f;
	reg [75:0] rows [0:8];
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) entropy_bit <= ~entropy_bit ^ reg_ack;
	rwg_top u_rwg_top (.mclk(mclk), .rst_n(rst_n), .soft_rst(soft_rst),
		.protected_mode(protected_mode), .entropy_bit(entropy_bit), .reg_req(reg_req),
		.reg_wr(reg_wr), .reg_from_embedded(reg_from_embedded), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.reg_refused(reg_refused), .pool_ready_flag(pool_ready_flag),
		.pool_underflow_flag(pool_underflow_flag));
	rwg_cpu_model u_rwg_cpu_model (.mclk(mclk), .reg_ack(reg_ack), .reg_refused(reg_refused),
		.reg_rdata(reg_rdata), .reg_req(reg_req), .reg_wr(reg_wr),
		.reg_from_embedded(reg_from_embedded), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	task chk(input [8*8-1:0] nm, input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("mismatch %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("compares %0d err_total %0d", compares, err_total);
			if (err_total == 0 && compares > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task rd(input [7:0] a);
		u_rwg_cpu_model.xfer(1'b1, 1'b0, a, 32'h0, q, f);
	endtask
	task wr(input [7:0] a, input [31:0] d);
		u_rwg_cpu_model.xfer(1'b1, 1'b1, a, d, q, f);
	endtask
	// polls the pool_ready_flag port every cycle, then checks the cycle count
	task await_ready(input integer lo, input integer hi);
		begin
			n = 0;
			while (pool_ready_flag !== 1'b1 && n < hi + 50) begin
				@(posedge mclk);
				n = n + 1;
			end
			if (pool_ready_flag !== 1'b1)
				err_total = err_total + 1;
			chk("rate", {31'h0, n >= lo && n <= hi}, 32'h1);
		end
	endtask
	// ----------------------------------------
	// table rows: embedded, protected, write, addr, wdata, rdata, refused
	// ----------------------------------------
	initial begin
		rows[0] = {3'h4, 8'h60, 64'h0, 1'b0};
		rows[1] = {3'h4, 8'h64, 64'h0, 1'b0};
		rows[2] = {3'h4, 8'h6c, 64'h0, 1'b0};
		rows[3] = {3'h5, 8'h64, 32'h00000f80, 32'h0, 1'b0};
		rows[4] = {3'h0, 8'h64, 32'h0, 32'h00000f80, 1'b0};
		rows[5] = {3'h3, 8'h60, 32'h1, 32'h0, 1'b1};
		rows[6] = {3'h2, 8'h64, 64'h0, 1'b1};
		rows[7] = {3'h6, 8'h60, 64'h0, 1'b0};
		rows[8] = {3'h4, 8'h70, 64'h0, 1'b0};
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		for (i = 0; i < 9; i = i + 1) begin
			@(posedge mclk);
			protected_mode <= rows[i][74];
			u_rwg_cpu_model.xfer(rows[i][75], rows[i][73], rows[i][72:65], rows[i][64:33], q, f);
			chk("rdata", q, rows[i][32:1]);
			chk("refused", {31'h0, f}, {31'h0, rows[i][0]});
		end
		$display("table done");
		begin : scenarios
			wr(8'h60, 32'h1);
			await_ready(2040, 2052);
			if (pool_ready_flag !== 1'b1)
				disable scenarios;
			rd(8'h6c);
			chk("ready", {31'h0, q[14]}, 32'h1);
			rd(8'h68);
			w0 = q;
			rd(8'h68);
			chk("fresh", {31'h0, q !== w0}, 32'h1);
			$display("rate done");
			repeat (6144) @(posedge mclk);
			wr(8'h60, 32'h0);
			for (i = 0; i < 4; i = i + 1)
				rd(8'h68);
			chk("full", {31'h0, pool_underflow_flag}, 32'h0);
			rd(8'h68);
			chk("under", {31'h0, pool_underflow_flag}, 32'h1);
			repeat (2100) @(posedge mclk);
			wr(8'h6c, 32'h0);
			rd(8'h6c);
			chk("status", q, 32'h00001000);
			$display("underflow done");
			@(posedge mclk);
			soft_rst <= 1'b1;
			@(posedge mclk);
			soft_rst <= 1'b0;
			rd(8'h64);
			chk("cfg_rst", q, 32'h0);
			rd(8'h6c);
			chk("st_rst", q, 32'h0);
			rd(8'h60);
			chk("en_rst", q, 32'h0);
			$display("soft reset done");
			// output divider 1024 with first divider 2
			wr(8'h64, 32'h00000f00);
			wr(8'h60, 32'h1);
			await_ready(4088, 4100);
			if (pool_ready_flag !== 1'b1)
				disable scenarios;
			@(posedge mclk);
			soft_rst <= 1'b1;
			@(posedge mclk);
			soft_rst <= 1'b0;
			// first divider 4 with output divider 512
			wr(8'h64, 32'h00000e80);
			wr(8'h60, 32'h1);
			await_ready(4088, 4100);
			$display("divider done");
		end
		chk("hang", u_rwg_cpu_model.hang, 32'h0);
		report_and_stop;
	end
endmodule
bind rwg_top rwg_top_assertions u_rwg_top_assertions (.mclk(mclk), .rst_n(rst_n),
	.soft_rst(soft_rst), .protected_mode(protected_mode), .entropy_bit(entropy_bit),
	.reg_req(reg_req), .reg_wr(reg_wr), .reg_from_embedded(reg_from_embedded),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
	.reg_refused(reg_refused), .pool_ready_flag(pool_ready_flag),
	.pool_underflow_flag(pool_underflow_flag));
